/* File: sld_pkg.sv */
// Purpose: shared constants for the serial led display loader
// Assumes: pclk at 50 MHz
// Notes: frame lengths select the target register
// Notes on behaviour
// RULE1 - serial bits captured on serial clock rising edge, msb first
// RULE2 - single device: 8-bit frame loads config, 24-bit loads display
// RULE3 - two chained devices need 32 or 48 clock cycles; code loads neither register on a 32 or 48 bit frame
// RULE4 - outputs change only when enable rises, shifting may be slow
// RULE5 - target register chosen by bit count at enable rise, no address
// RULE6 - config and display registers written independently in any order
// RULE7 - serial output shows shift register, changing on clock falling edge
// RULE8 - static shift path holds contents while serial clock stops
// RULE9 - serial clock unrelated to scan clock, transfers cross safely
// RULE10 - enable high: data out low, no shifting, port initialised
// RULE11 - host frames each transfer with enable low then high
// RULE12 - each enable rise starts a display blanking interval
// RULE13 - host changes enable only while serial clock is low
// RULE14 - resynchronise whenever enable high and serial clock low
// RULE15 - soft reset bit written low then high resets the device; code clears only the display register
// RULE16 - brightness bit high gives full drive, low gives half
// RULE17 - no decode mode forces e f g low, a-d lamps, h lamps
// RULE18 - segment mode: a-g drive segments, h drives decimal points
// RULE19 - five banks scanned in turn at 1 kHz, 20% duty each
// RULE20 - chained devices: data out feeds next data in
// RULE21 - h output decoding is the same in every decode mode
// RULE22 - invalid frame length leaves both registers unchanged
// RULE23 - bank anode pattern applied while its cathode switch is on
`default_nettype none
package sld_pkg;
   localparam int SLD_CLK_HZ = 50000000;
   localparam int SLD_CFG_BITS = 8;
   localparam int SLD_DSP_BITS = 24;
   localparam int SLD_BANKS = 5;
   localparam int SLD_REFRESH_HZ = 1000;
   localparam int SLD_BANK_CYCLES = SLD_CLK_HZ / (SLD_REFRESH_HZ * SLD_BANKS);
   localparam int SLD_BLANK_US = 20;
   localparam int SLD_BLANK_CYCLES = SLD_BLANK_US * (SLD_CLK_HZ / 1000000);
   localparam logic [7:0] SLD_CFG_RESET = 8'h00;
   localparam logic [23:0] SLD_DSP_RESET = 24'h000000;
   localparam int SLD_SOFT_RESET_POS = 0;
   localparam int SLD_BRIGHT_POS = 23;
   // apb register byte offsets
   localparam logic [11:0] SLD_ADDR_CFG = 12'h000;
   localparam logic [11:0] SLD_ADDR_DSP = 12'h004;
   localparam logic [11:0] SLD_ADDR_STATUS = 12'h008;
   localparam logic [11:0] SLD_ADDR_CTRL = 12'h00C;
   typedef enum logic [1:0] {
      SLD_IDLE = 2'b00,
      SLD_SHIFT = 2'b01,
      SLD_DESYNC = 2'b10
   } sld_port_state_t;
endpackage : sld_pkg
`default_nettype wire

/* File: sld_scan.sv */
// Purpose: bank scan and anode decode for the display loader
// Assumes: registers are already in the pclk domain
// Notes: decode table covers all sixteen hex values, no-decode per nibble
`default_nettype none
module sld_scan
   import sld_pkg::*;
#(
   parameter int BANK_CYCLES = SLD_BANK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] cfg,
   input wire logic [23:0] dsp,
   input wire logic blank,
   output logic [7:0] anode,
   output logic [4:0] bank,
   output logic half_drive
);
   logic [31:0] tick;
   logic [2:0] idx;
   logic [3:0] nib;
   logic dp;
   logic nodec;
   logic [6:0] seg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 32'h00000000;
         idx <= 3'h0;
      end else if (tick == 32'(BANK_CYCLES - 1)) begin
         tick <= 32'h00000000;
         idx <= (idx == 3'(SLD_BANKS - 1)) ? 3'h0 : 3'(idx + 3'h1); // RULE19
      end else begin
         tick <= 32'(tick + 32'h00000001);
      end
   end

   always_comb begin
      nib = 4'h0;
      dp = 1'b0;
      nodec = cfg[3'(idx) + 3'h1];
      case (idx)
         3'h0: nib = dsp[3:0];
         3'h1: nib = dsp[7:4];
         3'h2: nib = dsp[11:8];
         3'h3: nib = dsp[15:12];
         3'h4: nib = dsp[19:16];
         default: nib = 4'h0;
      endcase
      // dp nibble shared across banks; same in every mode
      dp = dsp[20] | (dsp[22:21] == 2'h3); // RULE21
      case (nib)
         4'h0: seg = 7'h3F;
         4'h1: seg = 7'h06;
         4'h2: seg = 7'h5B;
         4'h3: seg = 7'h4F;
         4'h4: seg = 7'h66;
         4'h5: seg = 7'h6D;
         4'h6: seg = 7'h7D;
         4'h7: seg = 7'h07;
         4'h8: seg = 7'h7F;
         4'h9: seg = 7'h6F;
         4'hA: seg = 7'h77;
         4'hB: seg = 7'h7C;
         4'hC: seg = 7'h39;
         4'hD: seg = 7'h5E;
         4'hE: seg = 7'h79;
         default: seg = 7'h71;
      endcase
      if (nodec) begin
         seg = {3'h0, nib}; // RULE17
      end
   end

   // registered outputs; blank and low-power (soft reset low) extinguish
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         anode <= 8'h00;
         bank <= 5'h00;
         half_drive <= 1'b1;
      end else begin
         half_drive <= ~dsp[SLD_BRIGHT_POS]; // RULE16
         if (blank || !cfg[SLD_SOFT_RESET_POS]) begin
            anode <= 8'h00;
            bank <= 5'h00;
         end else begin
            anode <= {dp, seg}; // RULE18 RULE23
            bank <= 5'(5'h01 << idx); // RULE19 RULE23
         end
      end
   end
endmodule : sld_scan
`default_nettype wire

/* File: sld_top.sv */
// Purpose: serial load port, register file and apb view of display loader
// Assumes: serial pins asynchronous to pclk, sampled through two flops
// Notes: serial clock must be well below pclk/4
// Notes: each pin phase must last at least four pclk to be seen reliably
`default_nettype none
module sld_top
   import sld_pkg::*;
#(
   parameter int BANK_CYCLES = SLD_BANK_CYCLES,
   parameter int BLANK_CYCLES = SLD_BLANK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ser_clk,
   input wire logic ser_din,
   input wire logic ser_enable_n,
   output logic ser_dout,
   output logic [7:0] anode,
   output logic [4:0] bank,
   output logic half_drive
);
   logic [1:0] clk_sync;
   logic [1:0] din_sync;
   logic [1:0] en_sync;
   logic clk_d;
   logic en_d;
   logic rise;
   logic fall;
   logic en_rise;
   sld_port_state_t state;
   logic [23:0] shreg;
   logic half_stage;
   logic [5:0] count;
   logic [7:0] cfg;
   logic [23:0] dsp;
   logic [31:0] blank_cnt;
   logic blank;
   logic [7:0] frames;
   logic [7:0] bad_frames;
   logic desync_seen;
   logic ctrl_clr;
   logic apb_wr;
   logic soft_was_low;
   logic frame_done;
   logic len_cfg;
   logic len_dsp;
   logic addr_hit;

   // serial clock domain is unrelated to pclk: two-flop sampling
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync <= 2'b00;
         din_sync <= 2'b00;
         en_sync <= 2'b11;
      end else begin
         clk_sync <= {clk_sync[0], ser_clk}; // RULE9
         din_sync <= {din_sync[0], ser_din};
         en_sync <= {en_sync[0], ser_enable_n};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d <= 1'b0;
         en_d <= 1'b1;
      end else begin
         clk_d <= clk_sync[1];
         en_d <= en_sync[1];
      end
   end

   assign rise = clk_sync[1] & ~clk_d;
   assign fall = ~clk_sync[1] & clk_d;
   // en_d resets high like the idle pin, so no false enable edge after reset
   assign en_rise = en_sync[1] & ~en_d;

   // a frame ends only on an enable rise seen while the port was in step;
   // a rise out of the desync state carries no trusted bit count
   assign frame_done = en_rise && (state == SLD_SHIFT);
   assign len_cfg = (count == 6'(SLD_CFG_BITS));
   assign len_dsp = (count == 6'(SLD_DSP_BITS));

   // framing state: enable edge while clock high loses sync
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SLD_IDLE;
      end else begin
         case (state)
            SLD_IDLE: begin
               if (!en_sync[1] && en_d) begin
                  state <= clk_sync[1] ? SLD_DESYNC : SLD_SHIFT;
               end
            end
            SLD_SHIFT: begin
               if (en_sync[1]) begin
                  state <= clk_sync[1] ? SLD_DESYNC : SLD_IDLE;
               end
            end
            SLD_DESYNC: begin
               if (en_sync[1] && !clk_sync[1]) begin
                  state <= SLD_IDLE; // RULE14
               end
            end
            default: state <= SLD_IDLE;
         endcase
      end
   end

   // static shift path, holds while the serial clock is stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg <= 24'h000000;
         count <= 6'h00;
      end else if (state != SLD_SHIFT || en_sync[1]) begin
         if (state != SLD_SHIFT) begin
            count <= 6'h00; // RULE10
         end
      end else if (rise) begin
         shreg <= {shreg[22:0], din_sync[1]}; // RULE1 RULE8
         if (count != 6'h3F) begin
            count <= 6'(count + 6'h01);
         end
      end
   end

   // half stage: msb retimed to the falling edge drives data out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_stage <= 1'b0;
      end else if (state != SLD_SHIFT || en_sync[1]) begin
         half_stage <= 1'b0; // RULE10
      end else if (fall) begin
         half_stage <= (count >= 6'(SLD_DSP_BITS)) ? shreg[23] :
                       shreg[7]; // RULE7 RULE20
      end
   end
   // cascade note: a single device forwards the byte in its active length
   assign ser_dout = half_stage;

   assign apb_wr = psel && penable && pwrite;

   // load on enable rise; frame length picks the target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= SLD_CFG_RESET;
         dsp <= SLD_DSP_RESET;
      end else if (frame_done) begin
         if (len_cfg) begin
            cfg <= shreg[7:0]; // RULE2 RULE5 RULE6
         end else if (len_dsp) begin
            dsp <= shreg; // RULE2 RULE4 RULE5 RULE6
         end
         // other lengths load nothing
      end else if (soft_was_low && cfg[SLD_SOFT_RESET_POS]) begin
         dsp <= SLD_DSP_RESET; // RULE15
      end else if (apb_wr && paddr == SLD_ADDR_CFG) begin
         cfg <= pwdata[7:0];
      end else if (apb_wr && paddr == SLD_ADDR_DSP) begin
         dsp <= pwdata[23:0];
      end
   end

   // soft reset: low then high clears display state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_was_low <= 1'b0;
      end else if (!cfg[SLD_SOFT_RESET_POS]) begin
         soft_was_low <= 1'b1; // RULE15
      end else begin
         soft_was_low <= 1'b0;
      end
   end

   // blanking counter; a repeat load dims a bank, as on the real part
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt <= 32'h00000000;
      end else if (en_rise) begin
         blank_cnt <= 32'(BLANK_CYCLES); // RULE12
      end else if (blank_cnt != 32'h00000000) begin
         blank_cnt <= 32'(blank_cnt - 32'h00000001);
      end
   end
   assign blank = (blank_cnt != 32'h00000000);

   // status counters; set wins over software clear
   assign ctrl_clr = apb_wr && paddr == SLD_ADDR_CTRL && pwdata[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frames <= 8'h00;
         bad_frames <= 8'h00;
         desync_seen <= 1'b0;
      end else begin
         if (frame_done) begin
            frames <= 8'(frames + 8'h01);
            if (!len_cfg && !len_dsp) begin
               bad_frames <= 8'(bad_frames + 8'h01); // RULE22
            end
         end else if (ctrl_clr) begin
            frames <= 8'h00;
            bad_frames <= 8'h00;
         end
         if (state == SLD_DESYNC) begin
            desync_seen <= 1'b1;
         end else if (ctrl_clr) begin
            desync_seen <= 1'b0;
         end
      end
   end

   // apb slave: zero wait states, unmapped reads zero with error
   assign pready = 1'b1;
   // one decode for the error flag keeps it in step with the register map
   always_comb begin
      case (paddr)
         SLD_ADDR_CFG: addr_hit = 1'b1;
         SLD_ADDR_DSP: addr_hit = 1'b1;
         SLD_ADDR_STATUS: addr_hit = 1'b1;
         SLD_ADDR_CTRL: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end
   always_comb begin
      pslverr = psel && penable && !addr_hit;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SLD_ADDR_CFG: prdata <= {24'h000000, cfg};
            SLD_ADDR_DSP: prdata <= {8'h00, dsp};
            SLD_ADDR_STATUS: prdata <= {8'h00, bad_frames, frames,
               2'h0, desync_seen, blank, state, state == SLD_SHIFT,
               en_sync[1]};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   sld_scan #(
      .BANK_CYCLES(BANK_CYCLES)
   ) u_scan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg),
      .dsp(dsp),
      .blank(blank),
      .anode(anode),
      .bank(bank),
      .half_drive(half_drive)
   );
endmodule : sld_top
`default_nettype wire

/* File: sld_top_monitor.sv */
// Purpose: port checks for the serial led display loader
// Assumes: serial pins reach pclk through two sync flops
// Notes: bound to sld_top
`default_nettype none
module sld_top_monitor
   import sld_pkg::*;
#(
   parameter int BANK_CYCLES = SLD_BANK_CYCLES,
   parameter int BLANK_CYCLES = SLD_BLANK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ser_clk,
   input wire logic ser_din,
   input wire logic ser_enable_n,
   input wire logic ser_dout,
   input wire logic [7:0] anode,
   input wire logic [4:0] bank,
   input wire logic half_drive
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   property p_idle_low; ser_enable_n [*5] |-> !ser_dout; endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("data out not low while idle");
   property p_blank; $rose(ser_enable_n) |-> ##[1:8] (bank == 5'h00);
   endproperty
   a_blank: assert property (p_blank)
      else $error("no blanking after enable rise");
   property p_hold; (!ser_enable_n && !psel) [*8] |-> $stable(half_drive);
   endproperty
   a_hold: assert property (p_hold)
      else $error("drive changed while shifting");
   property p_dout_fall;
      (ser_clk && !ser_enable_n) [*6] |-> $stable(ser_dout);
   endproperty
   a_dout_fall: assert property (p_dout_fall)
      else $error("data out moved while clock high");
   property p_bank_one; $onehot0(bank); endproperty
   a_bank_one: assert property (p_bank_one)
      else $error("more than one bank on");
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("access not ready");
   property p_err; acc && paddr > 12'h00C |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok;
      acc && paddr <= 12'h00C && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_stand; !(psel && !penable && !pwrite) |=> $stable(prdata);
   endproperty
   a_stand: assert property (p_stand) else $error("read data moved");
   c_load: cover property ($rose(ser_enable_n));
   c_err: cover property (acc && pslverr);
   c_last_bank: cover property (bank == 5'h10);
endmodule : sld_top_monitor
bind sld_top sld_top_monitor #(.BANK_CYCLES(BANK_CYCLES),
   .BLANK_CYCLES(BLANK_CYCLES)) i_sld_top_monitor (.*);
`default_nettype wire

/* File: sld_host_model.sv */
// Purpose: host serial port sending one frame per go pulse
// Assumes: 160 ns serial clock, four pclk per phase
// Notes: slow stretches the high phase to show a stalled clock
`default_nettype none
module sld_host_model
   import sld_pkg::*;
(
   input wire logic pclk,
   input wire logic go,
   input wire logic [5:0] nbits,
   input wire logic [47:0] frame,
   input wire logic slow,
   output logic ser_clk,
   output logic ser_din,
   output logic ser_enable_n,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int i;
   initial begin
      ser_clk = 1'b0;
      ser_din = 1'b0;
      ser_enable_n = 1'b1;
      busy = 1'b0;
   end
   always @(posedge pclk) begin
      if (go) begin
         busy <= 1'b1;
         repeat (4) @(posedge pclk);
         ser_enable_n <= 1'b0;
         for (i = int'(nbits) - 1; i >= 0; i--) begin
            repeat (2) @(posedge pclk);
            ser_din <= frame[i];
            repeat (2) @(posedge pclk);
            ser_clk <= 1'b1;
            repeat (slow ? 40 : 4) @(posedge pclk);
            ser_clk <= 1'b0;
         end
         repeat (4) @(posedge pclk);
         ser_enable_n <= 1'b1;
         ser_din <= ~ser_din;
         repeat (4) @(posedge pclk);
         busy <= 1'b0;
      end
   end
endmodule : sld_host_model
`default_nettype wire

/* File: serial_led_display_loader_tb.sv */
// Purpose: self-checking bench for the serial led display loader
// Assumes: host model drives the serial pins
// Notes: short scan and blank counts keep the run brief
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module serial_led_display_loader_tb;
   import sld_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BK = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic ser_clk, ser_din, ser_enable_n, ser_dout, half_drive;
   logic go, slow, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, rv, cfg_m, dsp_m;
   logic [7:0] anode;
   logic [4:0] bank, seen;
   logic [5:0] nbits;
   logic [47:0] frame;
   int mismatches, checks_done, seed, i;
   sld_top #(.BANK_CYCLES(BK), .BLANK_CYCLES(5)) i_sld_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ser_clk(ser_clk),
      .ser_din(ser_din), .ser_enable_n(ser_enable_n), .ser_dout(ser_dout),
      .anode(anode), .bank(bank), .half_drive(half_drive));
   sld_host_model i_sld_host_model (.pclk(pclk), .go(go), .nbits(nbits),
      .frame(frame), .slow(slow), .ser_clk(ser_clk), .ser_din(ser_din),
      .ser_enable_n(ser_enable_n), .busy(busy));
   function automatic logic [31:0] upd(input int n, input int len,
      input logic [47:0] f, input logic [31:0] cur);
      return (n == len) ? f[31:0] & ((32'h1 << len) - 32'h1) : cur;
   endfunction : upd
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic regs();
      apb(1'b0, SLD_ADDR_CFG, 32'h0);
      `CHK(q, cfg_m)
      apb(1'b0, SLD_ADDR_DSP, 32'h0);
      `CHK(q, dsp_m)
      `CHK(half_drive, ~dsp_m[23])
      `CHK(ser_dout, 1'b0)
   endtask : regs
   task automatic load(input int n, input logic [47:0] f, input logic s);
      logic [31:0] old;
      old = cfg_m;
      @(posedge pclk);
      nbits <= 6'(n);
      frame <= f;
      slow <= s;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      while (busy === 1'b1) @(posedge pclk);
      repeat (8) @(posedge pclk);
      cfg_m = upd(n, 8, f, cfg_m);
      dsp_m = upd(n, 24, f, dsp_m);
      if (!old[0] && cfg_m[0]) dsp_m = '0;
      regs();
   endtask : load
   task automatic close_out();
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #400000;
      mismatches++;
      close_out();
   end
   initial begin
      {psel, penable, pwrite, go, slow} = '0;
      paddr = '0;
      pwdata = '0;
      nbits = '0;
      frame = '0;
      mismatches = 0;
      checks_done = 0;
      seed = 98;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cfg_m = 32'(SLD_CFG_RESET);
      dsp_m = 32'(SLD_DSP_RESET);
      regs();
      apb(1'b0, 12'h010, 32'h0);
      `CHK({e, q}, 33'h100000000)
      load(8, 48'h01, 1'b0);
      load(24, 48'hFEDCBA, 1'b0);
      load(12, 48'hABC, 1'b0);
      load(32, 48'h12345601, 1'b0);
      for (i = 0; i < 6; i++) begin
         rv = 32'($random(seed));
         load((rv[31] ? 24 : 8), {16'h0, rv | 32'h1}, i[0]);
      end
      load(8, 48'h3F, 1'b1);
      seen = '0;
      repeat (6 * BK) begin
         @(posedge pclk);
         seen = seen | bank;
         if (bank !== 5'h00) `CHK(anode[6:4], 3'h0)
      end
      `CHK(seen, 5'h1F)
      load(8, 48'h00, 1'b0);
      load(8, 48'h01, 1'b0);
      apb(1'b1, SLD_ADDR_CFG, 32'h3);
      cfg_m = 32'h3;
      regs();
      close_out();
   end
endmodule : serial_led_display_loader_tb
`default_nettype wire
